// ### logic/adc_port_pkg.sv
// shared constants for the converter serial port and its host controller
package adc_port_pkg;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SCLK_MAX_HZ = 3_000_000;
  // half period of the serial clock, rounded up so the rate stays at or below the limit
  localparam int SCLK_HALF = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int RESET_ONES = 32;
  // command byte fields
  localparam int CMD_RDY_BIT = 7;
  localparam int CMD_RS_LSB = 4;
  localparam int CMD_RW_BIT = 3;
  localparam int CMD_CH_LSB = 0;
  localparam logic [2:0] RS_COMM = 3'h0;
  localparam logic [2:0] RS_SETUP = 3'h1;
  localparam logic [2:0] RS_CLOCK = 3'h2;
  localparam logic [2:0] RS_DATA = 3'h3;
  // set-up sequence bytes
  localparam logic [7:0] CMD_CLOCK_WR = 8'h20;
  localparam logic [7:0] CLOCK_INIT = 8'h0C;
  localparam logic [7:0] CMD_SETUP_WR = 8'h10;
  localparam logic [7:0] SETUP_INIT = 8'h40;
  localparam logic [7:0] CMD_DATA_RD = 8'h38;
  // clock and setup register fields
  localparam int CLK_DIV_BIT = 3;
  localparam int SETUP_MD_LSB = 6;
  localparam logic [1:0] MD_SELF_CAL = 2'h1;
  localparam int SETUP_FILTER_SYNC_HOLD_BIT = 0;
  // reset values
  localparam logic [7:0] COMM_RST = 8'h00;
  localparam logic [7:0] CLOCK_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h01;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // host controller registers on apb
  localparam int APB_AW = 12;
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RXDATA = 12'h008;
  localparam int CMDF_READ = 8;
  localparam int CMDF_WAIT = 9;
  localparam int CMDF_INIT = 10;
  localparam int CMDF_DATA = 11;
  localparam int STAT_BUSY = 0;
  localparam int STAT_READY = 1;
endpackage : adc_port_pkg

// ### logic/adc_link_if.sv
// serial link between the converter port and its host controller
`timescale 1ns/1ns
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;
  logic sample_ready_n;
  logic host_receive_frame_n;
  logic host_transmit_frame_n;
  logic miso;
  // pulled-up data out line
  assign miso = dout_oe ? dout : 1'b1;
  modport device (
    input sclk, cs_n, din,
    output dout, dout_oe, sample_ready_n
  );
  modport host (
    output sclk, cs_n, din, host_receive_frame_n, host_transmit_frame_n,
    input miso, sample_ready_n
  );
endinterface : adc_link_if

// ### logic/adc_serial_device.sv
// converter side of the serial command and data port
//
// Overview of operation
// - each transaction only writes or only reads
// - no output drive during write transactions
// - input line ignored during read transactions
// - host clock idles high between transfers
// - words travel most significant bit first
// - host serial clock at most 3 MHz
// - ready status readable in command register
// - chip select active when either frame active
// - command 0x20 selects clock register write
// - clock value 0x0C sets divider, 50 Hz
// - divide bit halves master clock internally
// - command 0x10 selects setup register write
// - setup value 0x40 starts self calibration
// - command 0x38 reads sixteen-bit data word
// - host waits for ready low before reading
// - host moves registers as eight-bit transfers
// - named transaction follows command immediately
// - ready low on new word, high after read
// - thirty-two ones reset the serial port
// - ready status is command register msb
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
module adc_serial_device #(
  parameter int DATA_W = 16
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  adc_link_if.device link, // serial link pins
  input wire logic [DATA_W-1:0] sample_word, // new conversion result
  input wire logic sample_valid, // result strobe
  input wire logic mclk_tick, // master clock enable pulse
  output logic [7:0] clock_reg, // clock register contents
  output logic [7:0] setup_reg, // setup register contents
  output logic [1:0] channel, // active input channel
  output logic cal_start, // self calibration start pulse
  output logic filter_sync_hold, // filter held in sync
  output logic mod_tick // internal converter clock enable
);
  import adc_port_pkg::*;

  if (DATA_W != 16) begin : g_bad_width
    $error("data word must be 16 bits");
  end

  typedef enum logic [2:0] {
    PH_CMD = 3'b001,
    PH_WR = 3'b010,
    PH_RD = 3'b100
  } phase_t;

  typedef struct packed {
    logic [2:0] sclk_sy;
    logic [1:0] cs_sy;
    logic [1:0] din_sy;
    phase_t phase;
    logic [2:0] rs;
    logic [1:0] ch;
    logic [4:0] bits;
    logic [4:0] len;
    logic [5:0] ones;
    logic [15:0] sh;
    logic [7:0] comm;
    logic [7:0] clock;
    logic [7:0] setup;
    logic [15:0] data;
    logic ready_n;
    logic dout;
    logic oe;
    logic cal;
    logic div;
    logic tick;
  } dev_st_t;

  dev_st_t q;
  dev_st_t n;
  logic sel;
  logic rise;
  logic fall;
  logic din_s;
  logic [7:0] cmd;

  ////////////////////////////////////////////////////////////////////////////
  // register decoding

  // bit count of the register named by a select code
  function automatic logic [4:0] len_of(input logic [2:0] rs);
    len_of = (rs == RS_DATA) ? 5'd16 : 5'd8;
  endfunction : len_of

  // read value, left aligned in the shifter
  function automatic logic [15:0] read_value(input logic [2:0] rs, input dev_st_t s);
    unique case (rs)
      // ready status rides in the top bit
      RS_COMM: read_value = {s.ready_n, s.comm[6:0], 8'h00};
      RS_SETUP: read_value = {s.setup, 8'h00};
      RS_CLOCK: read_value = {s.clock, 8'h00};
      RS_DATA: read_value = s.data;
      default: read_value = 16'h0000;
    endcase
  endfunction : read_value

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // edge detection on synchronised link pins
  assign sel = ~q.cs_sy[1];
  // rising edge samples, falling edge shifts out
  assign rise = sel & q.sclk_sy[1] & ~q.sclk_sy[2];
  assign fall = sel & ~q.sclk_sy[1] & q.sclk_sy[2];
  assign din_s = q.din_sy[1];
  assign cmd = {q.sh[6:0], din_s};

  always_comb begin
    n = q;
    n.sclk_sy = {q.sclk_sy[1:0], link.sclk};
    n.cs_sy = {q.cs_sy[0], link.cs_n};
    n.din_sy = {q.din_sy[0], link.din};
    n.cal = 1'b0;
    n.tick = 1'b0;

    // divide bit halves the master clock
    if (mclk_tick) begin
      if (q.clock[CLK_DIV_BIT]) begin
        n.div = ~q.div;
        n.tick = q.div;
      end else begin
        n.tick = 1'b1;
      end
    end

    // exactly one of the three phases is active
    unique case (q.phase)
      PH_CMD: begin
        if (rise) begin
          n.sh = {q.sh[14:0], din_s};
          n.bits = 5'(q.bits + 5'd1);
          if (q.bits == 5'd7) begin
            // the named transaction starts on the next clock
            n.bits = 5'd0;
            n.comm = cmd;
            n.rs = cmd[CMD_RS_LSB +: 3];
            n.ch = cmd[CMD_CH_LSB +: 2];
            n.len = len_of(cmd[CMD_RS_LSB +: 3]);
            if (cmd[CMD_RW_BIT]) begin
              // data register loads all sixteen bits for the read
              n.phase = PH_RD;
              // command register reads back ready status over the low seven bits just taken
              n.sh = read_value(cmd[CMD_RS_LSB +: 3], n);
            end else if (cmd[CMD_RS_LSB +: 3] != RS_COMM) begin
              n.phase = PH_WR;
            end
          end
        end
      end
      PH_WR: begin
        if (rise) begin
          n.sh = {q.sh[14:0], din_s};
          n.bits = 5'(q.bits + 5'd1);
          if (q.bits == 5'(q.len - 5'd1)) begin
            n.bits = 5'd0;
            n.phase = PH_CMD;
            // clock register takes the written byte
            if (q.rs == RS_CLOCK) begin
              n.clock = cmd;
            end
            // setup register takes the written byte
            if (q.rs == RS_SETUP) begin
              n.setup = cmd;
              // self calibration mode starts a calibration
              n.cal = (cmd[SETUP_MD_LSB +: 2] == MD_SELF_CAL);
            end
          end
        end
      end
      PH_RD: begin
        // next bit goes out on the falling edge
        if (fall) begin
          n.dout = q.sh[15];
          n.sh = {q.sh[14:0], 1'b0};
        end
        // input line not sampled while reading
        if (rise) begin
          n.bits = 5'(q.bits + 5'd1);
          if (q.bits == 5'(q.len - 5'd1)) begin
            n.bits = 5'd0;
            n.phase = PH_CMD;
            // ready returns high once the data read completes
            if (q.rs == RS_DATA) begin
              n.ready_n = 1'b1;
            end
          end
        end
      end
      default: n.phase = PH_CMD;
    endcase

    // a run of ones on the input line resets the port
    if (rise && q.phase != PH_RD) begin
      if (!din_s) begin
        n.ones = 6'd0;
      end else if (q.ones == 6'(RESET_ONES - 1)) begin
        n.ones = 6'd0;
        n.phase = PH_CMD;
        n.bits = 5'd0;
      end else begin
        n.ones = 6'(q.ones + 6'd1);
      end
    end

    // new word pulls ready low; this wins over the read clearing it
    if (sample_valid) begin
      n.data = sample_word;
      n.ready_n = 1'b0;
    end

    // drive only while selected in a read
    n.oe = sel & (q.phase == PH_RD) & (n.phase == PH_RD);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{
        sclk_sy: 3'h7, cs_sy: 2'h3, din_sy: 2'h3, phase: PH_CMD, rs: RS_COMM,
        bits: 5'h00, len: 5'h08, ones: 6'h00, sh: 16'h0000, comm: COMM_RST,
        clock: CLOCK_RST, setup: SETUP_RST, data: DATA_RST, ready_n: 1'b1,
        dout: 1'b1, oe: 1'b0, cal: 1'b0, ch: 2'h0, div: 1'b0, tick: 1'b0
      };
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign link.dout = q.dout;
  assign link.dout_oe = q.oe;
  // ready pin and status bit share one flop
  assign link.sample_ready_n = q.ready_n;
  assign clock_reg = q.clock;
  assign setup_reg = q.setup;
  assign channel = q.ch;
  assign cal_start = q.cal;
  assign filter_sync_hold = q.setup[SETUP_FILTER_SYNC_HOLD_BIT];
  assign mod_tick = q.tick;

endmodule : adc_serial_device

// ### logic/adc_serial_host.sv
// host controller driving the converter serial port from apb registers
`timescale 1ns/1ns
module adc_serial_host (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [adc_port_pkg::APB_AW-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  adc_link_if.host link // serial link pins
);
  import adc_port_pkg::*;

  if (SCLK_HALF < 8) begin : g_bad_half
    $error("serial clock half period too short for pin synchronisers");
  end

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_WAIT = 4'b0010,
    H_SHIFT = 4'b0100,
    H_GAP = 4'b1000
  } hstate_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    hstate_t state;
    logic [1:0] mode;
    logic [1:0] step;
    logic [7:0] tx;
    logic rd;
    logic [15:0] rx;
    logic [1:0] miso_sy;
    logic [1:0] rdy_sy;
    logic sclk;
    logic cs_n;
    logic rfs_n;
    logic tfs_n;
    logic din;
    logic [5:0] div;
    logic [3:0] bits;
    logic [7:0] sh;
  } host_st_t;

  host_st_t q;
  host_st_t n;
  logic [9:0] job;
  logic acc_wr;

  ////////////////////////////////////////////////////////////////////////////
  // byte list of each job: {last, read, byte}

  function automatic logic [9:0] job_byte(
    input logic [1:0] mode, input logic [1:0] step, input logic [7:0] tx, input logic rd
  );
    job_byte = {1'b1, rd, tx};
    if (mode == 2'd1) begin
      unique case (step)
        2'd0: job_byte = {2'b00, CMD_CLOCK_WR};
        2'd1: job_byte = {2'b00, CLOCK_INIT};
        2'd2: job_byte = {2'b00, CMD_SETUP_WR};
        default: job_byte = {2'b10, SETUP_INIT};
      endcase
    end else if (mode == 2'd2) begin
      unique case (step)
        2'd0: job_byte = {2'b00, CMD_DATA_RD};
        2'd1: job_byte = {2'b01, 8'h00};
        default: job_byte = {2'b11, 8'h00};
      endcase
    end
  endfunction : job_byte

  assign job = job_byte(q.mode, q.step, q.tx, q.rd);
  assign acc_wr = psel & penable & q.pready & pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [9:0] nj;
    nj = 10'h000;
    n = q;
    n.miso_sy = {q.miso_sy[0], link.miso};
    n.rdy_sy = {q.rdy_sy[0], link.sample_ready_n};
    // apb: ready in the access cycle after every setup cycle
    n.pready = psel & ~penable;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        REG_CMD: n.prdata = {24'h00_0000, q.tx};
        REG_STATUS: n.prdata = {30'h0000_0000, ~q.rdy_sy[1], q.state != H_IDLE};
        REG_RXDATA: n.prdata = {16'h0000, q.rx};
        default: n.pslverr = 1'b1;
      endcase
      // a new job while one runs is refused
      if (pwrite && paddr == REG_CMD && q.state != H_IDLE) begin
        n.pslverr = 1'b1;
      end
    end

    unique case (q.state)
      H_IDLE: begin
        // a write refused in its setup cycle stays refused even if the job ends meanwhile
        if (acc_wr && paddr == REG_CMD && !q.pslverr) begin
          n.tx = pwdata[7:0];
          n.rd = pwdata[CMDF_READ];
          n.step = 2'd0;
          n.mode = pwdata[CMDF_INIT] ? 2'd1 : (pwdata[CMDF_DATA] ? 2'd2 : 2'd0);
          // data jobs wait for the ready line first
          n.state = (pwdata[CMDF_WAIT] | pwdata[CMDF_DATA]) ? H_WAIT : H_SHIFT;
          n.sh = pwdata[CMDF_INIT] ? CMD_CLOCK_WR :
                 (pwdata[CMDF_DATA] ? CMD_DATA_RD : pwdata[7:0]);
          n.div = 6'd0;
          n.bits = 4'd0;
        end
      end
      H_WAIT: begin
        if (!q.rdy_sy[1]) begin
          n.state = H_SHIFT;
        end
      end
      H_SHIFT: begin
        // select is active whenever either frame is active
        n.cs_n = 1'b0;
        n.tfs_n = job[8];
        n.rfs_n = ~job[8];
        n.div = 6'(q.div + 6'd1);
        // clock toggles every half period from the divider
        if (q.div == 6'(SCLK_HALF - 1) && !q.cs_n) begin
          n.div = 6'd0;
          n.sclk = ~q.sclk;
          if (q.sclk) begin
            n.din = job[8] ? 1'b1 : q.sh[7];
          end else begin
            n.sh = {q.sh[6:0], q.miso_sy[1]};
            n.bits = 4'(q.bits + 4'd1);
            if (q.bits == 4'd7) begin
              n.bits = 4'd0;
              // the two data bytes pair high byte first
              if (job[8]) begin
                n.rx = {q.rx[7:0], q.sh[6:0], q.miso_sy[1]};
              end
              if (job[9]) begin
                n.state = H_GAP;
              end else begin
                // the next eight-bit transfer follows at once
                n.step = 2'(q.step + 2'd1);
                nj = job_byte(q.mode, 2'(q.step + 2'd1), q.tx, q.rd);
                n.sh = nj[7:0];
              end
            end
          end
        end
      end
      H_GAP: begin
        n.din = 1'b1;
        n.div = 6'(q.div + 6'd1);
        if (q.div == 6'(SCLK_HALF - 1)) begin
          n.div = 6'd0;
          n.cs_n = 1'b1;
          n.rfs_n = 1'b1;
          n.tfs_n = 1'b1;
          n.state = H_IDLE;
        end
      end
      default: n.state = H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{
        pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000, state: H_IDLE,
        mode: 2'h0, step: 2'h0, tx: 8'h00, rd: 1'b0, rx: 16'h0000,
        miso_sy: 2'h3, rdy_sy: 2'h3, sclk: 1'b1, cs_n: 1'b1, rfs_n: 1'b1,
        tfs_n: 1'b1, din: 1'b1, div: 6'h00, bits: 4'h0, sh: 8'h00
      };
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.din = q.din;
  assign link.host_receive_frame_n = q.rfs_n;
  assign link.host_transmit_frame_n = q.tfs_n;

endmodule : adc_serial_host

// ### testbench/adc_port_monitor.sv
// concurrent checks on the serial link between the host controller and the converter port
`timescale 1ns/1ns
module adc_port_monitor
  import adc_port_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic sclk, // serial clock
  input wire logic cs_n, // chip select, active low
  input wire logic din, // host to device data
  input wire logic dout, // device data out
  input wire logic dout_oe, // device drive enable
  input wire logic miso, // resolved data out line
  input wire logic sample_ready_n, // new word waiting, active low
  input wire logic host_receive_frame_n, // read frame, active low
  input wire logic host_transmit_frame_n // write frame, active low
);
  logic sclk_q;
  logic [7:0] run_q;
  logic [5:0] rises_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // length of the present serial clock level, rising edges within the present job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b1;
      run_q <= 8'h00;
      rises_q <= 6'h00;
    end else begin
      sclk_q <= sclk;
      if (sclk != sclk_q) run_q <= 8'h00;
      else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
      if (cs_n) rises_q <= 6'h00;
      else if (sclk && !sclk_q) rises_q <= rises_q + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////
  // link assertions
  no_drive_write_a: assert property (
    !host_transmit_frame_n && !sclk |-> !dout_oe) else $error("data out driven in write byte");
  one_direction_a: assert property (
    host_receive_frame_n || host_transmit_frame_n) else $error("read and write frames together");
  deselect_quiet_a: assert property (
    cs_n [*6] |-> !dout_oe && miso) else $error("data out driven while deselected");
  dout_steady_a: assert property (
    (sclk && dout_oe) [*8] |-> $stable(dout)) else $error("data out moved while clock high");
  din_on_fall_a: assert property (
    $changed(din) && !cs_n && !sclk |-> $fell(sclk)) else $error("data in moved off a fall");
  idle_clock_a: assert property (
    cs_n && $past(cs_n) |-> sclk) else $error("serial clock low while idle");
  frame_select_a: assert property (
    !host_receive_frame_n || !host_transmit_frame_n |-> !cs_n) else $error("frame without select");
  half_period_a: assert property (
    sclk != sclk_q |-> run_q >= SCLK_HALF - 1) else $error("serial clock half period too short");
  whole_bytes_a: assert property (
    $rose(cs_n) |-> rises_q inside {6'd8, 6'd16, 6'd24, 6'd32}) else $error("job not whole bytes");
  ready_after_read_a: assert property (
    $rose(sample_ready_n) |-> !cs_n && !host_receive_frame_n) else $error("ready rose off a read");
  // main scenarios reached
  cover property ($rose(dout_oe));
  cover property ($fell(sample_ready_n));
  cover property ($rose(cs_n) && rises_q == 6'd24);
  cover property ($rose(cs_n) && rises_q == 6'd32);
endmodule : adc_port_monitor

// ### testbench/tb_sigma_delta_adc_serial_port.sv
// self-checking bench: apb host controller drives the converter port over the link
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_sigma_delta_adc_serial_port;
  import adc_port_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] sample_word = 16'h0000;
  logic sample_valid = 1'b0;
  logic mclk_tick = 1'b0;
  logic [7:0] clock_reg;
  logic [7:0] setup_reg;
  logic [1:0] channel;
  logic cal_start;
  logic filter_sync_hold;
  logic mod_tick;
  int mismatches = 0;
  int checks = 0;
  int cal_n = 0;
  int mod_n = 0;
  adc_link_if link ();
  adc_serial_device adc_serial_device_i (.pclk(pclk), .presetn(presetn), .link(link),
    .sample_word(sample_word), .sample_valid(sample_valid), .mclk_tick(mclk_tick),
    .clock_reg(clock_reg), .setup_reg(setup_reg), .channel(channel), .cal_start(cal_start),
    .filter_sync_hold(filter_sync_hold), .mod_tick(mod_tick));
  adc_serial_host adc_serial_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  adc_port_monitor adc_port_monitor_i (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
    .cs_n(link.cs_n), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe),
    .miso(link.miso), .sample_ready_n(link.sample_ready_n),
    .host_receive_frame_n(link.host_receive_frame_n),
    .host_transmit_frame_n(link.host_transmit_frame_n));
  // 100 MHz system clock
  always #5 pclk = ~pclk;
  // count device pulses
  always @(posedge pclk) begin
    if (cal_start === 1'b1) cal_n++;
    if (mod_tick === 1'b1) mod_n++;
  end
  ////////////////////////////////////////////////////////////
  // print counts and verdict, then stop
  task automatic give_verdict();
    $display("counts: checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // one apb transfer: setup cycle, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) give_verdict_after_miss();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic give_verdict_after_miss();
    mismatches++;
    give_verdict();
  endtask : give_verdict_after_miss
  // transfer and compare: read data on reads, error flag always
  task automatic xfer(input string nm, input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic eerr);
    logic [31:0] r;
    logic e;
    apb(wr, a, d, r, e);
    if (!wr) `CHK(nm, d, r)
    `CHK("pslverr", eerr, e)
  endtask : xfer
  // poll status until the controller is idle
  task automatic wait_idle();
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      n++;
    end while (r[STAT_BUSY] !== 1'b0 && n < 3000);
    if (n >= 3000) give_verdict_after_miss();
  endtask : wait_idle
  // one conversion result strobe
  task automatic sample(input logic [15:0] w);
    @(posedge pclk);
    sample_word <= w;
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    @(posedge pclk);
  endtask : sample
  // master clock pulses, one every third cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      mclk_tick <= 1'b1;
      @(posedge pclk);
      mclk_tick <= 1'b0;
      @(posedge pclk);
    end
    // let the pulse counter see the last output pulse before anyone reads it
    @(posedge pclk);
  endtask : ticks
  // select the command register for reading, read one byte back
  task automatic cmd_read(input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    xfer("cmd", 1'b1, REG_CMD, 32'h008, 1'b0);
    wait_idle();
    xfer("rdbyte", 1'b1, REG_CMD, 32'h100, 1'b0);
    wait_idle();
    apb(1'b0, REG_RXDATA, 32'h0, r, e);
    `CHK("cmd_reg", exp, r[7:0])
  endtask : cmd_read
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int m0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("clock_reg", CLOCK_RST, clock_reg)
    `CHK("setup_reg", SETUP_RST, setup_reg)
    `CHK("ready_n", 1'b1, link.sample_ready_n)
    `CHK("sclk", 1'b1, link.sclk)
    xfer("status", 1'b0, REG_STATUS, 32'h0, 1'b0);
    xfer("unmapped", 1'b0, 12'h0FC, 32'h0, 1'b1);
    m0 = mod_n;
    ticks(8);
    `CHK("mod_ticks", 8, mod_n - m0)
    $display("test reset done");
    xfer("init", 1'b1, REG_CMD, 32'h400, 1'b0);
    xfer("busy", 1'b1, REG_CMD, 32'h020, 1'b1);
    wait_idle();
    `CHK("clock_reg", CLOCK_INIT, clock_reg)
    `CHK("setup_reg", SETUP_INIT, setup_reg)
    `CHK("channel", 2'h0, channel)
    `CHK("filter_sync_hold", 1'b0, filter_sync_hold)
    `CHK("cal", 1, cal_n)
    m0 = mod_n;
    ticks(8);
    `CHK("mod_ticks", 4, mod_n - m0)
    $display("test init done");
    sample(16'hA5C3);
    `CHK("ready_n", 1'b0, link.sample_ready_n)
    repeat (4) @(posedge pclk);
    xfer("status", 1'b0, REG_STATUS, 32'h2, 1'b0);
    xfer("data", 1'b1, REG_CMD, 32'h800, 1'b0);
    wait_idle();
    xfer("rxdata", 1'b0, REG_RXDATA, 32'h0000A5C3, 1'b0);
    `CHK("ready_n", 1'b1, link.sample_ready_n)
    $display("test data read done");
    xfer("data", 1'b1, REG_CMD, 32'h800, 1'b0);
    repeat (300) @(posedge pclk);
    `CHK("cs_n", 1'b1, link.cs_n)
    sample(16'h1234);
    wait_idle();
    xfer("rxdata", 1'b0, REG_RXDATA, 32'h00001234, 1'b0);
    $display("test ready wait done");
    cmd_read(8'h88);
    sample(16'h0F0F);
    cmd_read(8'h08);
    $display("test command read done");
    give_verdict();
  end
endmodule : tb_sigma_delta_adc_serial_port
